// ---- hdl/csc_serial_config.sv ----
// Serial load register and active matrix registers of the crosspoint
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.svh"

module csc_serial_config
	import csc_pkg::*;
(
	// System clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Serial link
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	output logic o_dout,
	// Control pins
	input wire logic i_mode,
	input wire logic i_cfg,
	input wire logic i_reset,
	input wire logic i_broadcast_input_zero,
	// Active matrix state
	output logic [`CSC_NUM_OUT*`CSC_SEL_BITS-1:0] o_sel,
	output logic [`CSC_NUM_OUT-1:0] o_off
);

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------

	logic [1:0] lrst_q;
	logic lrst_n;
	logic arm_q;
	logic arm_seen_q;
	logic tgl_q;
	logic shift;
	logic [`CSC_FRAME_BITS-1:0] shift_q;

	// Reset brought into the link clock
	always_ff @(posedge i_sclk) begin
		lrst_q <= {lrst_q[0], i_rst_n};
	end
	assign lrst_n = lrst_q[1];

	// Armed by a rising edge seen with select low
	always_ff @(posedge i_sclk) begin
		if (!lrst_n) begin
			arm_q <= 1'h0;
		end else begin
			arm_q <= !i_cs_n;
		end
	end

	// Shift only while armed and selected
	assign shift = arm_q && !i_cs_n;

	// Load register, filled from the top on falling edges
	always_ff @(negedge i_sclk) begin
		if (!lrst_n) begin
			shift_q <= '0;
		end else if (shift) begin
			shift_q <= {i_din, shift_q[`CSC_FRAME_BITS-1:1]};
		end
	end

	// Oldest bit leaves first toward the next device
	assign o_dout = shift_q[0];

	// One toggle per frame marks fresh data
	always_ff @(negedge i_sclk) begin
		if (!lrst_n) begin
			arm_seen_q <= 1'h0;
			tgl_q <= 1'h0;
		end else begin
			arm_seen_q <= arm_q;
			if (shift && !arm_seen_q) begin
				tgl_q <= !tgl_q;
			end
		end
	end

	// ------------------------------------------------------------
	// System domain: pin filters
	// ------------------------------------------------------------

	logic [`CSC_NUM_PINS-1:0] pin_raw;
	logic [`CSC_NUM_PINS-1:0] lvl_q;
	logic [`CSC_SYNC_STAGES-1:0] sync_q [`CSC_NUM_PINS];

	assign pin_raw = {tgl_q, i_broadcast_input_zero, i_reset, i_mode,
		i_cfg};

	// Three stages; a change counts once stages two and three agree
	for (genvar p = 0; p < `CSC_NUM_PINS; p++) begin : g_pin
		always_ff @(posedge i_clk) begin
			if (!i_rst_n) begin
				sync_q[p] <= '0;
				lvl_q[p] <= 1'h0;
			end else begin
				sync_q[p] <= {sync_q[p][1:0], pin_raw[p]};
				if (sync_q[p][1] == sync_q[p][2]) begin
					lvl_q[p] <= sync_q[p][2];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// System domain: configure strobe
	// ------------------------------------------------------------

	logic cfg_prev_q;
	logic applied_q;
	logic cfg_rise;
	logic new_data;
	logic rst_lvl;
	logic bzero_lvl;
	logic apply;
	csc_mode_t mode;
	logic [`CSC_WORD_BITS-1:0] word;
	logic [`CSC_AW_OUT_BITS-1:0] word_out;
	logic [`CSC_NUM_OUT-1:0] addr_hot;
	logic [`CSC_NUM_OUT*`CSC_SEL_BITS-1:0] frame_sel;
	logic [`CSC_NUM_OUT-1:0] frame_off;
	logic [`CSC_NUM_OUT*`CSC_SEL_BITS-1:0] hot_mask;

	assign rst_lvl = lvl_q[`CSC_PIN_RST];
	assign bzero_lvl = lvl_q[`CSC_PIN_BZERO];
	assign mode = csc_mode_t'(lvl_q[`CSC_PIN_MODE]);
	assign cfg_rise = lvl_q[`CSC_PIN_CFG] && !cfg_prev_q;
	assign new_data = lvl_q[`CSC_PIN_TGL] != applied_q;
	assign apply = cfg_rise && new_data && !rst_lvl && !bzero_lvl;

	// Addressed word sits in the last eight bits shifted in
	assign word = shift_q[`CSC_WORD_BASE +: `CSC_WORD_BITS];
	assign word_out = word[`CSC_AW_OUT_LSB +: `CSC_AW_OUT_BITS];
	assign addr_hot = `CSC_NUM_OUT'(1) << word_out;

	// Edge memory and record of the last frame applied
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cfg_prev_q <= 1'h0;
			applied_q <= 1'h0;
		end else begin
			cfg_prev_q <= lvl_q[`CSC_PIN_CFG];
			if (apply) begin
				applied_q <= lvl_q[`CSC_PIN_TGL];
			end
		end
	end

	// ------------------------------------------------------------
	// System domain: active matrix, one entry per output
	// ------------------------------------------------------------

	for (genvar g = 0; g < `CSC_NUM_OUT; g++) begin : g_out
		// Fields of this output within the serial frame
		assign frame_sel[g*`CSC_SEL_BITS +: `CSC_SEL_BITS] =
			shift_q[g*`CSC_FIELD_BITS +: `CSC_SEL_BITS];
		assign frame_off[g] =
			shift_q[g*`CSC_FIELD_BITS+`CSC_FIELD_OFF];
		// Select bits owned by this output, set when it is addressed
		assign hot_mask[g*`CSC_SEL_BITS +: `CSC_SEL_BITS] =
			{`CSC_SEL_BITS{addr_hot[g]}};
		always_ff @(posedge i_clk) begin
			if (!i_rst_n || rst_lvl) begin
				o_sel[g*`CSC_SEL_BITS +: `CSC_SEL_BITS] <= `CSC_SEL_RESET;
				o_off[g] <= `CSC_OFF_RESET;
			end else if (bzero_lvl) begin
				o_sel[g*`CSC_SEL_BITS +: `CSC_SEL_BITS] <= `CSC_SEL_RESET;
				o_off[g] <= `CSC_OFF_ON;
			end else if (apply) begin
				if (mode == CSC_MODE_SERIAL) begin
					o_sel[g*`CSC_SEL_BITS +: `CSC_SEL_BITS] <=
						frame_sel[g*`CSC_SEL_BITS +: `CSC_SEL_BITS];
					o_off[g] <= frame_off[g];
				end else if (addr_hot[g]) begin
					o_sel[g*`CSC_SEL_BITS +: `CSC_SEL_BITS] <=
						word[`CSC_AW_IN_LSB +: `CSC_SEL_BITS];
					o_off[g] <= word[`CSC_AW_OFF_POS];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	sequence s_cfg_new;
		cfg_rise && new_data && !rst_lvl && !bzero_lvl;
	endsequence

	sequence s_shift;
		shift;
	endsequence

	a_reset_all_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		rst_lvl |=> (o_off == '1 && o_sel == '0))
		else $error("reset pin did not turn all outputs off");

	a_reset_wins_bzero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		rst_lvl && bzero_lvl |=> o_off == '1)
		else $error("broadcast overrode reset");

	a_bzero_all_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		bzero_lvl && !rst_lvl |=> (o_off == '0 && o_sel == '0))
		else $error("broadcast did not route input zero everywhere");

	a_cfg_stale_none: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cfg_rise && !new_data && !rst_lvl && !bzero_lvl
		|=> $stable(o_sel) && $stable(o_off))
		else $error("configure without new data changed the matrix");

	a_serial_frame_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_cfg_new ##0 (mode == CSC_MODE_SERIAL) |=>
		o_sel[3:0] == $past(shift_q[3:0]) && o_off[0] == $past(shift_q[4])
		&& o_sel[31:28] == $past(shift_q[38:35])
		&& o_off[7] == $past(shift_q[39]))
		else $error("serial frame fields landed in the wrong outputs");

	a_addr_one_output: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_cfg_new ##0 (mode == CSC_MODE_ADDR) |=>
		((o_off ^ $past(o_off)) & ~$past(addr_hot)) == '0
		&& o_off[$past(word_out)] == $past(word[7]))
		else $error("addressed word touched the wrong output");

	a_shift_in_order: assert property (@(negedge i_sclk) disable iff (!lrst_n)
		s_shift |=> shift_q == {$past(i_din), $past(shift_q[39:1])})
		else $error("load register did not shift the sampled bit in");

	a_cs_high_ignore: assert property (@(negedge i_sclk) disable iff (!lrst_n)
		i_cs_n |=> $stable(shift_q))
		else $error("data shifted while select was high");

	a_chain_dout: assert property (@(negedge i_sclk) disable iff (!lrst_n)
		s_shift |=> o_dout == $past(shift_q[1]))
		else $error("serial output did not pass the old contents on");

	// ------------------------------------------------------------
	// Further checks, built from the steps of each transfer
	// ------------------------------------------------------------

	// Link armed by a rising edge and still selected
	sequence s_armed_sel;
		arm_q && !i_cs_n;
	endsequence

	// First falling edge of a frame, which marks fresh data
	sequence s_frame_start;
		shift && !arm_seen_q;
	endsequence

	// Accepted configure pulse in serial mode
	sequence s_serial_apply;
		s_cfg_new ##0 (mode == CSC_MODE_SERIAL);
	endsequence

	// Accepted configure pulse in addressed mode
	sequence s_addr_apply;
		s_cfg_new ##0 (mode == CSC_MODE_ADDR);
	endsequence

	a_serial_all_fields: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		s_serial_apply |=> o_sel == $past(frame_sel)
		&& o_off == $past(frame_off))
		else $error("serial frame did not set every output");

	a_addr_sel_only: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		s_addr_apply |=>
		((o_sel ^ $past(o_sel)) & ~$past(hot_mask)) == '0)
		else $error("addressed word changed another input address");

	a_addr_sel_value: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		s_addr_apply |=>
		o_sel[$past(word_out)*`CSC_SEL_BITS +: `CSC_SEL_BITS]
		== $past(word[`CSC_AW_IN_LSB +: `CSC_SEL_BITS]))
		else $error("addressed word set the wrong input address");

	a_hold_no_apply: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		!apply && !rst_lvl && !bzero_lvl
		|=> $stable(o_sel) && $stable(o_off))
		else $error("matrix changed without an accepted configure");

	a_cfg_filter_wait: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		sync_q[`CSC_PIN_CFG][1] != sync_q[`CSC_PIN_CFG][2]
		|=> $stable(lvl_q[`CSC_PIN_CFG]))
		else $error("configure level moved before its stages agreed");

	a_arm_on_select: assert property (@(posedge i_sclk)
		disable iff (!lrst_n)
		!i_cs_n |=> arm_q)
		else $error("rising edge with select low did not arm the link");

	a_disarm_deselect: assert property (@(posedge i_sclk)
		disable iff (!lrst_n)
		i_cs_n |=> !arm_q)
		else $error("rising edge with select high left the link armed");

	a_unarmed_no_shift: assert property (@(negedge i_sclk)
		disable iff (!lrst_n)
		!arm_q |=> $stable(shift_q))
		else $error("load register shifted before the first rising edge");

	a_top_takes_din: assert property (@(negedge i_sclk)
		disable iff (!lrst_n)
		s_armed_sel |=> shift_q[`CSC_FRAME_BITS-1] == $past(i_din))
		else $error("sampled bit did not enter the top of the register");

	a_frame_marks: assert property (@(negedge i_sclk)
		disable iff (!lrst_n)
		s_frame_start |=> tgl_q != $past(tgl_q))
		else $error("new frame was not marked as fresh data");

	a_mark_once_frame: assert property (@(negedge i_sclk)
		disable iff (!lrst_n)
		!(shift && !arm_seen_q) |=> $stable(tgl_q))
		else $error("fresh data mark moved inside a frame");

	a_dout_holds: assert property (@(negedge i_sclk)
		disable iff (!lrst_n)
		!shift |=> $stable(o_dout))
		else $error("serial output moved without a shift");

endmodule : csc_serial_config

`default_nettype wire

// ---- hdl/csc_consts.svh ----
// Constants of the crosspoint serial configuration block
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// ------------------------------------------------------------
// Matrix shape
// ------------------------------------------------------------
`define CSC_NUM_OUT 8
`define CSC_SEL_BITS 4
`define CSC_FRAME_BITS 40
`define CSC_FIELD_BITS 5
`define CSC_FIELD_OFF 4

// ------------------------------------------------------------
// Addressed word, held in the top byte of the load register
// ------------------------------------------------------------
`define CSC_WORD_BITS 8
`define CSC_WORD_BASE 32
`define CSC_AW_OUT_LSB 0
`define CSC_AW_OUT_BITS 3
`define CSC_AW_IN_LSB 3
`define CSC_AW_OFF_POS 7

// ------------------------------------------------------------
// Reset and broadcast values of a matrix entry
// ------------------------------------------------------------
`define CSC_SEL_RESET 4'h0
`define CSC_OFF_RESET 1'h1
`define CSC_OFF_ON 1'h0

// ------------------------------------------------------------
// Pin filter: stages and pin index
// ------------------------------------------------------------
`define CSC_SYNC_STAGES 3
`define CSC_NUM_PINS 5
`define CSC_PIN_CFG 0
`define CSC_PIN_MODE 1
`define CSC_PIN_RST 2
`define CSC_PIN_BZERO 3
`define CSC_PIN_TGL 4

`endif

// ---- hdl/csc_pkg.sv ----
// Types of the crosspoint serial configuration block
package csc_pkg;

	// Programming format chosen by the mode pin
	typedef enum logic {
		CSC_MODE_SERIAL = 1'h0,
		CSC_MODE_ADDR = 1'h1
	} csc_mode_t;

	// Input address of one output
	typedef logic [3:0] csc_sel_t;

endpackage : csc_pkg

// ---- verification/csc_host_model.sv ----
// Host model that drives the serial link of the crosspoint
`timescale 1ns/1ps
`default_nettype none
module csc_host_model (
	// Serial link
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din,
	input wire logic i_dout
);
	// Old load register contents seen on the data out pin
	logic [79:0] got;
	// Link clock starts low and select is high outside frames
	initial begin
		o_sclk = 1'h0;
		o_cs_n = 1'h1;
		o_din = 1'h0;
		got = 80'h0;
	end
	// Clock edges with select high, which must shift nothing
	task idle(input int n);
		#7;
		repeat (n) begin
			#15 o_sclk = 1'h1;
			#15 o_sclk = 1'h0;
		end
	endtask : idle
	// Send n bits, frame bit 0 first
	task send(input logic [79:0] v, input int n);
		#7 o_cs_n = 1'h0;
		#15 o_sclk = 1'h1;
		for (int k = 0; k < n; k++) begin
			#1 o_din = v[k];
			got[k] = i_dout;
			#14 o_sclk = 1'h0;
			#15 o_sclk = 1'h1;
		end
		#1 o_din = ~o_din;
		o_cs_n = 1'h1;
		#14 o_sclk = 1'h0;
		#15 o_sclk = 1'h1;
		#15 o_sclk = 1'h0;
	endtask : send
endmodule : csc_host_model
`default_nettype wire

// ---- verification/tb_crosspoint_serial_config.sv ----
// Self-checking bench of the crosspoint serial configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_total++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_crosspoint_serial_config
	import csc_pkg::*;
;
	logic clk, rst_n, sclk, cs_n, din, dout, mode, cfg, rst_pin, bzero;
	logic [31:0] sel, exp_sel;
	logic [7:0] off, exp_off;
	logic [39:0] f1, f2;
	int err_total = 0;
	int cmp_count = 0;
	// ------------------------------------------------------------
	// Design, host model and clock
	// ------------------------------------------------------------
	csc_serial_config dut (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_din(din), .o_dout(dout), .i_mode(mode),
		.i_cfg(cfg), .i_reset(rst_pin), .i_broadcast_input_zero(bzero),
		.o_sel(sel), .o_off(off));
	csc_host_model h (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
		.i_dout(dout));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	function automatic logic [39:0] mk(input logic [31:0] s,
		input logic [7:0] f);
		logic [39:0] v;
		for (int n = 0; n < 8; n++) v[5*n+:5] = {f[n], s[4*n+:4]};
		return v;
	endfunction : mk
	// Configure strobe with settled load register
	task pulse_cfg;
		tick(5);
		cfg = 1'h1;
		tick(4);
		cfg = 1'h0;
		tick(6);
	endtask : pulse_cfg
	task check;
		`CHK("sel", exp_sel, sel)
		`CHK("off", exp_off, off)
	endtask : check
	task give_verdict;
		$display("Compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_serial;
		f1 = mk(32'h89ABCDEF, 8'hA5);
		h.send({40'h0, f1}, 40);
		check();
		pulse_cfg();
		exp_sel = 32'h89ABCDEF;
		exp_off = 8'hA5;
		check();
		$display("serial frame test done");
	endtask : t_serial
	task t_shift;
		f2 = mk(32'h01234567, 8'h3C);
		h.send({40'h0, f2}, 40);
		`CHK("dout", f1, h.got[39:0])
		pulse_cfg();
		exp_sel = 32'h01234567;
		exp_off = 8'h3C;
		check();
		$display("shift out test done");
	endtask : t_shift
	// Two-device chain: 80 bits, the first 40 move on to the next part
	task t_chain;
		h.send({f1, mk(32'h76543210, 8'h81)}, 80);
		`CHK("chain old", f2, h.got[39:0])
		`CHK("chain next", mk(32'h76543210, 8'h81), h.got[79:40])
		pulse_cfg();
		exp_sel = 32'h89ABCDEF;
		exp_off = 8'hA5;
		check();
		$display("chain test done");
	endtask : t_chain
	task t_addr;
		mode = 1'h1;
		h.send({72'h0, 8'h55}, 8);
		pulse_cfg();
		exp_sel[20+:4] = 4'hA;
		exp_off[5] = 1'h0;
		check();
		h.send({72'h0, 8'h98}, 8);
		pulse_cfg();
		exp_sel[3:0] = 4'h3;
		exp_off[0] = 1'h1;
		check();
		$display("addressed test done");
	endtask : t_addr
	task t_pins;
		mode = 1'h0;
		bzero = 1'h1;
		h.send({40'h0, f1}, 40);
		pulse_cfg();
		exp_sel = 32'h0;
		exp_off = 8'h00;
		check();
		bzero = 1'h0;
		tick(6);
		check();
		pulse_cfg();
		exp_sel = 32'h89ABCDEF;
		exp_off = 8'hA5;
		check();
		rst_pin = 1'h1;
		bzero = 1'h1;
		tick(6);
		exp_sel = 32'h0;
		exp_off = 8'hFF;
		check();
		rst_pin = 1'h0;
		bzero = 1'h0;
		pulse_cfg();
		check();
		$display("control pin test done");
	endtask : t_pins
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{rst_n, mode, cfg, rst_pin, bzero} = 5'h0;
		fork
			h.idle(4);
			tick(4);
		join
		rst_n = 1'h1;
		h.idle(2);
		tick(5);
		exp_sel = 32'h0;
		exp_off = 8'hFF;
		check();
		t_serial();
		t_shift();
		t_chain();
		t_addr();
		t_pins();
		give_verdict();
	end
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
endmodule : tb_crosspoint_serial_config
`default_nettype wire
